// ---- hdl/sacw_clkdiv.sv ----
// converter clock enable divider
`timescale 1ns/1ps
module sacw_clkdiv
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // control
  input  wire logic       run_in,
  input  wire logic [2:0] div_code_in,
  // one-cycle converter clock enable
  output logic            tick_out
);
  import sacw_pkg::*;

  sacw_div_t  st;
  sacw_div_t  next_st;
  logic [3:0] last;

  always_comb
  begin
    case (div_code_in)
      3'b000:  last = 4'h0;
      3'b001:  last = 4'h1;
      3'b010:  last = 4'h3;
      3'b011:  last = 4'h7;
      default: last = 4'hF;
    endcase
    tick_out = run_in && st.cnt >= last;
    next_st  = st;
    if (rst_in || !run_in || tick_out)
      next_st.cnt = 4'h0;
    else
      next_st.cnt = st.cnt + 4'h1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    st <= next_st;
  end
endmodule

// ---- hdl/sacw_pkg.sv ----
// shared constants and types for the converter control block
package sacw_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] SACW_ADDR_AIS = 8'hBB;
  localparam logic [7:0] SACW_ADDR_CFG = 8'hBC;
  localparam logic [7:0] SACW_ADDR_RLO = 8'hBE;
  localparam logic [7:0] SACW_ADDR_RHI = 8'hBF;
  localparam logic [7:0] SACW_ADDR_GTL = 8'hC4;
  localparam logic [7:0] SACW_ADDR_GTH = 8'hC5;
  localparam logic [7:0] SACW_ADDR_LTL = 8'hC6;
  localparam logic [7:0] SACW_ADDR_LTH = 8'hC7;
  localparam logic [7:0] SACW_ADDR_CTL = 8'hE8;
  // values after reset
  localparam logic [7:0] SACW_RST_AIS = 8'h00;
  localparam logic [7:0] SACW_RST_CFG = 8'h60;
  localparam logic [7:0] SACW_RST_RES = 8'h00;
  localparam logic [7:0] SACW_RST_GT  = 8'hFF;
  localparam logic [7:0] SACW_RST_LT  = 8'h00;
  localparam logic [7:0] SACW_RST_CTL = 8'h00;
  // writable bits; reserved bits read zero
  localparam logic [7:0] SACW_MASK_AIS = 8'h3F;
  localparam logic [7:0] SACW_MASK_CFG = 8'hE7;
  // field positions
  localparam int SACW_AIS_EN     = 5;
  localparam int SACW_CFG_DIV_HI = 7;
  localparam int SACW_CFG_DIV_LO = 5;
  localparam int SACW_CFG_GAIN_HI = 2;
  localparam int SACW_CTL_ON     = 7;
  localparam int SACW_CTL_TM     = 6;
  localparam int SACW_CTL_DONE   = 5;
  localparam int SACW_CTL_BUSY   = 4;
  localparam int SACW_CTL_SRC_HI = 3;
  localparam int SACW_CTL_SRC_LO = 2;
  localparam int SACW_CTL_WIN    = 1;
  localparam int SACW_CTL_LJ     = 0;
  // start sources
  localparam logic [1:0] SACW_SRC_SW  = 2'b00;
  localparam logic [1:0] SACW_SRC_TMR = 2'b11;
  // sequence lengths in converter clocks
  localparam int SACW_TRACK_CLKS = 3;
  localparam int SACW_CONV_CLKS  = 16;

  typedef enum logic [2:0]
  {
    SACW_IDLE  = 3'b001,
    SACW_TRACK = 3'b010,
    SACW_CONV  = 3'b100
  } sacw_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } sacw_sfr_req_t;

  typedef struct packed {
    logic        power;
    logic        track;
    logic        convert;
    logic [31:0] pin_route;
    logic [5:0]  gain_sel;
  } sacw_analog_t;

  typedef struct packed {
    logic [3:0] cnt;
  } sacw_div_t;

  typedef struct packed {
    sacw_state_t  state;
    logic [4:0]   cnt;
    logic [7:0]   ais;
    logic [7:0]   cfg;
    logic [7:0]   ctl;
    logic [7:0]   rlo;
    logic [7:0]   rhi;
    logic [7:0]   gtl;
    logic [7:0]   gth;
    logic [7:0]   ltl;
    logic [7:0]   lth;
    logic [12:0]  sync_a;
    logic [12:0]  sync_b;
    logic [7:0]   rdata;
    logic         irq;
    sacw_analog_t ana;
  } sacw_core_t;
endpackage

// ---- hdl/sacw_top.sv ----
// converter control: registers, start and track sequencing, results
`timescale 1ns/1ps
// How it works
// - route enable off routes no pin
// - two bits choose port zero to three
// - three bits choose pin zero to seven
// - only the chosen pin is routed
// - gain code picks 1,2,4,8,16 or 0.5
// - gain resets to unity
// - converter clock is 1 to 16 clocks
// - start by busy write or timer overflow
// - busy write starts only in mode 00
// - busy reads one while converting
// - busy fall at conversion end sets done, requests interrupt when irq_enable_in is high
// - done flag sticks until software clears
// - enable bit powers the converter
// - track mode 0 tracks except converting
// - track mode 1 tracks three clocks
// - right justify with optional sign extension
// - left justify, low nibble reads zero
// - justify bit selects placement
// - window compare flags each matching result
// - two 16-bit limits, byte registers
module sacw_top
(
  // clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  // special function register port
  input  wire sacw_pkg::sacw_sfr_req_t sfr_req_in,
  output logic [7:0]                   sfr_rdata_out,
  // start and interrupt gating
  input  wire logic                    timer_ovf_in,
  input  wire logic                    irq_enable_in,
  // analog converter side
  input  wire logic [11:0]             sar_code_in,
  input  wire logic                    diff_mode_in,
  output sacw_pkg::sacw_analog_t       analog_out,
  output logic                         sar_clk_en_out,
  output logic                         irq_req_out
);
  import sacw_pkg::*;

  sacw_core_t st;
  sacw_core_t next_st;
  logic       tick;
  logic       wr_ctl;
  logic       sw_start;
  logic       hw_start;
  logic       go;
  logic       busy;
  logic       track_end;
  logic       finish;
  logic       win_match;
  logic [7:0] cand_hi;
  logic [7:0] cand_lo;

  function automatic logic [5:0] sacw_gain(input logic [2:0] code);
    // one-hot: bit0 x0.5, bit1 x1 .. bit5 x16
    case (code)
      3'b000:  sacw_gain = 6'h02;
      3'b001:  sacw_gain = 6'h04;
      3'b010:  sacw_gain = 6'h08;
      3'b011:  sacw_gain = 6'h10;
      3'b100:  sacw_gain = 6'h20;
      3'b101:  sacw_gain = 6'h20;
      default: sacw_gain = 6'h01;
    endcase
  endfunction

  sacw_clkdiv u_div
  (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .run_in      (st.ctl[SACW_CTL_ON]),
    .div_code_in (st.cfg[SACW_CFG_DIV_HI:SACW_CFG_DIV_LO]),
    .tick_out    (tick)
  );

  sacw_window u_win
  (
    .word_in     ({cand_hi, cand_lo}),
    .gt_limit_in ({st.gth, st.gtl}),
    .lt_limit_in ({st.lth, st.ltl}),
    .match_out   (win_match)
  );

  assign wr_ctl = sfr_req_in.wr && sfr_req_in.addr == SACW_ADDR_CTL;
  assign sw_start = wr_ctl && sfr_req_in.wdata[SACW_CTL_BUSY]
    && sfr_req_in.wdata[SACW_CTL_SRC_HI:SACW_CTL_SRC_LO]
       == SACW_SRC_SW;
  assign hw_start = timer_ovf_in
    && st.ctl[SACW_CTL_SRC_HI:SACW_CTL_SRC_LO] == SACW_SRC_TMR;
  assign go = st.ctl[SACW_CTL_ON] && st.state == SACW_IDLE
    && (sw_start || hw_start);
  assign busy = st.state != SACW_IDLE;
  assign track_end = st.state == SACW_TRACK && tick
    && st.cnt == 5'(SACW_TRACK_CLKS - 1);
  assign finish = st.state == SACW_CONV && tick && st.ctl[SACW_CTL_ON]
    && st.cnt == 5'(SACW_CONV_CLKS - 1);

  // placement of the synchronised converter code
  always_comb
  begin
    if (st.ctl[SACW_CTL_LJ])
    begin
      cand_hi = st.sync_b[11:4];
      cand_lo = {st.sync_b[3:0], 4'h0};
    end
    else
    begin
      cand_hi = {st.sync_b[12] ? {4{st.sync_b[11]}} : 4'h0,
                 st.sync_b[11:8]};
      cand_lo = st.sync_b[7:0];
    end
  end

  always_comb
  begin
    next_st        = st;
    next_st.irq    = 1'b0;
    next_st.sync_a = {diff_mode_in, sar_code_in};
    next_st.sync_b = st.sync_a;
    // register writes
    if (sfr_req_in.wr)
    begin
      case (sfr_req_in.addr)
        SACW_ADDR_AIS: next_st.ais = sfr_req_in.wdata & SACW_MASK_AIS;
        SACW_ADDR_CFG: next_st.cfg = sfr_req_in.wdata & SACW_MASK_CFG;
        SACW_ADDR_RLO: next_st.rlo = sfr_req_in.wdata;
        SACW_ADDR_RHI: next_st.rhi = sfr_req_in.wdata;
        SACW_ADDR_GTL: next_st.gtl = sfr_req_in.wdata;
        SACW_ADDR_GTH: next_st.gth = sfr_req_in.wdata;
        SACW_ADDR_LTL: next_st.ltl = sfr_req_in.wdata;
        SACW_ADDR_LTH: next_st.lth = sfr_req_in.wdata;
        SACW_ADDR_CTL:
        begin
          // busy is never stored; writing 0 there does nothing
          next_st.ctl = sfr_req_in.wdata;
          next_st.ctl[SACW_CTL_BUSY] = 1'b0;
        end
        default: ;
      endcase
    end
    // start, track and conversion sequence
    case (st.state)
      SACW_IDLE:
      begin
        if (go)
        begin
          next_st.cnt = 5'h00;
          if (st.ctl[SACW_CTL_TM])
            next_st.state = SACW_TRACK;
          else
            next_st.state = SACW_CONV;
        end
      end
      SACW_TRACK:
      begin
        if (track_end)
        begin
          next_st.cnt   = 5'h00;
          next_st.state = SACW_CONV;
        end
        else if (tick)
          next_st.cnt = st.cnt + 5'h01;
      end
      SACW_CONV:
      begin
        if (finish)
        begin
          next_st.state = SACW_IDLE;
          next_st.rhi   = cand_hi;
          next_st.rlo   = cand_lo;
          // set wins over a clear written in the same cycle
          next_st.ctl[SACW_CTL_DONE] = 1'b1;
          if (win_match)
            next_st.ctl[SACW_CTL_WIN] = 1'b1;
          next_st.irq = irq_enable_in;
        end
        else if (tick)
          next_st.cnt = st.cnt + 5'h01;
      end
      default: next_st.state = SACW_IDLE;
    endcase
    // shutdown aborts any conversion
    if (!st.ctl[SACW_CTL_ON])
      next_st.state = SACW_IDLE;
    // read data, registered
    case (sfr_req_in.addr)
      SACW_ADDR_AIS: next_st.rdata = st.ais;
      SACW_ADDR_CFG: next_st.rdata = st.cfg;
      SACW_ADDR_RLO: next_st.rdata = st.rlo;
      SACW_ADDR_RHI: next_st.rdata = st.rhi;
      SACW_ADDR_GTL: next_st.rdata = st.gtl;
      SACW_ADDR_GTH: next_st.rdata = st.gth;
      SACW_ADDR_LTL: next_st.rdata = st.ltl;
      SACW_ADDR_LTH: next_st.rdata = st.lth;
      SACW_ADDR_CTL: next_st.rdata = {st.ctl[7:5], busy, st.ctl[3:0]};
      default:       next_st.rdata = 8'h00;
    endcase
    // analog side controls
    next_st.ana.power = st.ctl[SACW_CTL_ON];
    if (st.ctl[SACW_CTL_TM])
      next_st.ana.track = st.ctl[SACW_CTL_ON]
        && st.state == SACW_TRACK;
    else
      next_st.ana.track = st.ctl[SACW_CTL_ON]
        && st.state != SACW_CONV;
    next_st.ana.convert = st.state == SACW_CONV;
    if (st.ais[SACW_AIS_EN])
      next_st.ana.pin_route = 32'h0000_0001 << st.ais[4:0];
    else
      next_st.ana.pin_route = 32'h0000_0000;
    next_st.ana.gain_sel = sacw_gain(st.cfg[SACW_CFG_GAIN_HI:0]);
    // synchronous reset
    if (rst_in)
    begin
      next_st       = '0;
      next_st.state = SACW_IDLE;
      next_st.ais   = SACW_RST_AIS;
      next_st.cfg   = SACW_RST_CFG;
      next_st.ctl   = SACW_RST_CTL;
      next_st.rlo   = SACW_RST_RES;
      next_st.rhi   = SACW_RST_RES;
      next_st.gtl   = SACW_RST_GT;
      next_st.gth   = SACW_RST_GT;
      next_st.ltl   = SACW_RST_LT;
      next_st.lth   = SACW_RST_LT;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    st <= next_st;
  end

  assign sfr_rdata_out  = st.rdata;
  assign analog_out     = st.ana;
  assign sar_clk_en_out = tick;
  assign irq_req_out    = st.irq;

  property p_sw_start;
    @(posedge ref_clk_in) disable iff (rst_in)
    (st.state == SACW_IDLE && st.ctl[SACW_CTL_ON] && sw_start)
      |=> busy && st.state != SACW_IDLE;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("busy write did not start a conversion");

  property p_wrong_mode;
    @(posedge ref_clk_in) disable iff (rst_in)
    (st.state == SACW_IDLE && wr_ctl && !timer_ovf_in
      && sfr_req_in.wdata[SACW_CTL_SRC_HI:SACW_CTL_SRC_LO] != SACW_SRC_SW)
      |=> st.state == SACW_IDLE;
  endproperty
  a_wrong_mode: assert property (p_wrong_mode)
    else $error("busy write started outside software mode");

  property p_done_set;
    @(posedge ref_clk_in) disable iff (rst_in)
    finish |=> st.ctl[SACW_CTL_DONE] && !busy
      && irq_req_out == $past(irq_enable_in);
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("completion did not set done flag and request");

  property p_done_sticky;
    @(posedge ref_clk_in) disable iff (rst_in)
    (st.ctl[SACW_CTL_DONE] && !wr_ctl) |=> st.ctl[SACW_CTL_DONE];
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("done flag cleared without a write");

  property p_gain_reset;
    @(posedge ref_clk_in)
    rst_in |=> st.cfg[SACW_CFG_GAIN_HI:0] == 3'b000
      && st.cfg == SACW_RST_CFG;
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("gain not unity after reset");

  property p_route_one;
    @(posedge ref_clk_in) disable iff (rst_in)
    st.ais[SACW_AIS_EN] |=> $onehot(analog_out.pin_route)
      && analog_out.pin_route[$past(st.ais[4:0])];
  endproperty
  a_route_one: assert property (p_route_one)
    else $error("routed pins differ from the selected pin");

  property p_route_off;
    @(posedge ref_clk_in) disable iff (rst_in)
    !st.ais[SACW_AIS_EN] |=> analog_out.pin_route == 32'h0000_0000;
  endproperty
  a_route_off: assert property (p_route_off)
    else $error("pin routed while routing disabled");

  property p_track_len;
    @(posedge ref_clk_in) disable iff (rst_in)
    (go && st.ctl[SACW_CTL_TM]) |=> st.state == SACW_TRACK
      ##1 (st.state == SACW_TRACK || !st.ctl[SACW_CTL_ON]);
  endproperty
  a_track_len: assert property (p_track_len)
    else $error("tracked phase did not begin on start");

  property p_track_end;
    @(posedge ref_clk_in) disable iff (rst_in)
    track_end && st.ctl[SACW_CTL_ON] |=> st.state == SACW_CONV
      ##1 !analog_out.track;
  endproperty
  a_track_end: assert property (p_track_end)
    else $error("conversion did not follow three tracking clocks");

  property p_no_track_conv;
    @(posedge ref_clk_in) disable iff (rst_in)
    st.state == SACW_CONV |=> !analog_out.track && analog_out.convert;
  endproperty
  a_no_track_conv: assert property (p_no_track_conv)
    else $error("tracking during conversion");

  property p_left_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    (finish && st.ctl[SACW_CTL_LJ]) |=> st.rlo[3:0] == 4'h0
      && st.rhi == $past(st.sync_b[11:4]);
  endproperty
  a_left_zero: assert property (p_left_zero)
    else $error("left justified result misplaced");

  property p_win_set;
    @(posedge ref_clk_in) disable iff (rst_in)
    (finish && win_match) |=> st.ctl[SACW_CTL_WIN]
      ##1 (st.ctl[SACW_CTL_WIN] || $past(wr_ctl));
  endproperty
  a_win_set: assert property (p_win_set)
    else $error("window flag not set on match");

  property p_shutdown;
    @(posedge ref_clk_in) disable iff (rst_in)
    !st.ctl[SACW_CTL_ON] |=> !busy && !analog_out.power;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("converter active while disabled");

  c_sw_conv: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    sw_start && go ##[1:300] finish);
  c_tmr_track: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    hw_start && go && st.ctl[SACW_CTL_TM]);
  c_win_hit: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && win_match);
endmodule

// ---- hdl/sacw_window.sv ----
// window compare of a result word against two limits
`timescale 1ns/1ps
module sacw_window
(
  // operands
  input  wire logic [15:0] word_in,
  input  wire logic [15:0] gt_limit_in,
  input  wire logic [15:0] lt_limit_in,
  // result
  output logic             match_out
);
  always_comb
  begin
    // inside window when limits cross, else outside
    if (lt_limit_in > gt_limit_in)
      match_out = word_in > gt_limit_in && word_in < lt_limit_in;
    else
      match_out = word_in < lt_limit_in || word_in > gt_limit_in;
  end
endmodule

// ---- testbench/sacw_core_model.sv ----
// processor core model driving the register port and timer overflow
`timescale 1ns/1ps
module sacw_core_model
(
  // clock
  input  wire logic              ref_clk_in,
  // register port
  output sacw_pkg::sacw_sfr_req_t req_out,
  input  wire logic [7:0]        rdata_in,
  // timer overflow
  output logic                   ovf_out
);
  import sacw_pkg::*;

  initial
  begin
    req_out = '0;
    ovf_out = 1'b0;
  end

  // write strobe lasts one cycle; zero in done or window bits clears them
  task automatic sfr_wr(input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge ref_clk_in);
    req_out.addr = a;
    req_out.wdata = d;
    req_out.wr = 1'b1;
    @(negedge ref_clk_in);
    req_out.wr = 1'b0;
  endtask

  // address held, data taken one cycle later
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    req_out.addr = a;
    @(negedge ref_clk_in);
    d = rdata_in;
  endtask

  task automatic tmr();
    @(negedge ref_clk_in);
    ovf_out = 1'b1;
    @(negedge ref_clk_in);
    ovf_out = 1'b0;
  endtask
endmodule

// ---- testbench/test_sacw_top.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_sacw_top;
  import sacw_pkg::*;
  logic          ref_clk_in;
  logic          rst_in;
  logic          irq_en;
  logic          diff;
  logic          ovf;
  logic          tick;
  logic          irq;
  logic [11:0]   code;
  logic [7:0]    rdata;
  logic [7:0]    v;
  logic [31:0]   r;
  logic [31:0]   seed;
  sacw_sfr_req_t req;
  sacw_analog_t  ana;
  int            n_errors;
  int            total_checks;
  logic [7:0]    ra [7] = '{8'hBB, 8'hBC, 8'hBE, 8'hBF, 8'hC5, 8'hE8, 8'h90};
  logic [7:0]    rv [7] = '{8'h00, 8'h60, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};

  sacw_top sacw_top_inst
  (
    .ref_clk_in     (ref_clk_in),
    .rst_in         (rst_in),
    .sfr_req_in     (req),
    .sfr_rdata_out  (rdata),
    .timer_ovf_in   (ovf),
    .irq_enable_in  (irq_en),
    .sar_code_in    (code),
    .diff_mode_in   (diff),
    .analog_out     (ana),
    .sar_clk_en_out (tick),
    .irq_req_out    (irq)
  );

  sacw_core_model sacw_core_model_inst
  (
    .ref_clk_in (ref_clk_in),
    .req_out    (req),
    .rdata_in   (rdata),
    .ovf_out    (ovf)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [5:0] gain_exp(input logic [2:0] g);
    if (g[2:1] == 2'b11)
      return 6'h01;
    return g[2] ? 6'h20 : 6'h02 << g[1:0];
  endfunction

  function automatic logic [15:0] just(input logic lj);
    return lj ? {code, 4'h0} : {{4{diff & code[11]}}, code};
  endfunction

  function automatic logic win(input logic [15:0] w, g, l);
    return (l > g) ? (w > g && w < l) : (w < l || w > g);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one conversion with random code, divider, limits and interrupt gate
  task automatic conv(input logic tm, input logic [1:0] src, input logic lj);
    logic [7:0]  c;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [31:0] lim;
    int          t;
    int          n;
    int          pt;
    int          d;
    int          nt;
    logic        ok;
    logic        seen;
    logic [7:0]  ev;
    r = rnd();
    lim = rnd();
    code = r[11:0];
    diff = r[12];
    irq_en = r[13];
    d = r[18] ? 16 : 1 << r[17:16];
    nt = tm ? 19 : 16;
    c = {1'b1, tm, 2'b00, src, 1'b0, lj};
    sacw_core_model_inst.sfr_wr(8'hC5, lim[31:24]);
    sacw_core_model_inst.sfr_wr(8'hC4, lim[23:16]);
    sacw_core_model_inst.sfr_wr(8'hC7, lim[15:8]);
    sacw_core_model_inst.sfr_wr(8'hC6, lim[7:0]);
    sacw_core_model_inst.sfr_wr(8'hBC, {r[18:16], 5'h00});
    sacw_core_model_inst.sfr_wr(8'hE8, c);
    if (src == SACW_SRC_SW)
      sacw_core_model_inst.sfr_wr(8'hE8, c | 8'h10);
    else
      sacw_core_model_inst.tmr();
    t = 0;
    n = 0;
    pt = 0;
    ok = 1'b1;
    seen = 1'b0;
    // end of conversion found by the done flag, not busy
    while (rdata[5] !== 1'b1 && n < 700)
    begin
      if (n > 0 && rdata[4] !== 1'b1)
        ok = 1'b0;
      if (ana.convert === 1'b1 && ana.track !== 1'b0)
        ok = 1'b0;
      if (irq === 1'b1)
        seen = 1'b1;
      pt = int'(tick);
      t += int'(tick);
      n++;
      @(negedge ref_clk_in);
    end
    check(t - pt, nt);
    check(n >= (nt - 1) * d + 2 && n <= nt * d + 1, 1);
    check({ok, rdata[4]}, 2'b10);
    check(seen, irq_en);
    sacw_core_model_inst.sfr_rd(8'hBF, hi);
    sacw_core_model_inst.sfr_rd(8'hBE, lo);
    check({hi, lo}, just(lj));
    sacw_core_model_inst.sfr_rd(8'hE8, v);
    ev = {c[7:6], 2'b10, c[3:2], win(just(lj), lim[31:16], lim[15:0]), lj};
    check(v, ev);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    close_out();
  end

  initial
  begin
    seed = 32'd70733;
    rst_in = 1'b1;
    irq_en = 1'b0;
    diff = 1'b0;
    code = 12'h000;
    n_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      sacw_core_model_inst.sfr_rd(ra[i], v);
      check(v, rv[i]);
    end
    check({ana.power, ana.gain_sel}, 7'h02);
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      sacw_core_model_inst.sfr_wr(8'hBB, r[7:0]);
      sacw_core_model_inst.sfr_rd(8'hBB, v);
      check(v, r[7:0] & 8'h3F);
      check(ana.pin_route,
            r[5] ? 32'h1 << r[4:0] : 32'h0);
    end
    for (int g = 0; g < 8; g++)
    begin
      sacw_core_model_inst.sfr_wr(8'hBC, {5'b10111, 3'(g)});
      sacw_core_model_inst.sfr_rd(8'hBC, v);
      check(v, {5'b10100, 3'(g)});
      check(ana.gain_sel, gain_exp(3'(g)));
    end
    for (int i = 0; i < 12; i++)
      conv(i[0], SACW_SRC_SW, i[1]);
    conv(1'b0, SACW_SRC_TMR, 1'b0);
    conv(1'b1, SACW_SRC_TMR, 1'b1);
    for (int m = 1; m < 3; m++)
    begin
      sacw_core_model_inst.sfr_wr(8'hE8, 8'h80 | 8'(m << 2));
      sacw_core_model_inst.sfr_wr(8'hE8, 8'h90 | 8'(m << 2));
      sacw_core_model_inst.tmr();
      repeat (40) @(negedge ref_clk_in);
      sacw_core_model_inst.sfr_rd(8'hE8, v);
      check(v, 8'h80 | 8'(m << 2));
    end
    sacw_core_model_inst.sfr_wr(8'hE8, 8'h80);
    sacw_core_model_inst.sfr_rd(8'hE8, v);
    check({ana.power, ana.track, ana.convert}, 3'b110);
    sacw_core_model_inst.sfr_wr(8'hE8, 8'h00);
    sacw_core_model_inst.sfr_rd(8'hE8, v);
    check({ana.power, ana.track, tick}, 3'b000);
    close_out();
  end
endmodule
